/* rtl/cpr_rx_channel_fsm.sv */
// serial link receiver with per-channel receive state machines
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "cpr_defines.svh"

module cpr_rx_channel_fsm #(
    parameter int         NUM_CH    = 4,
    parameter logic [7:0] BASE_ADDR = 8'h00
) (
    input  wire logic             ref_clk,
    input  wire logic             reset_n,
    input  wire logic             ce,
    input  wire logic             link_clk,
    input  wire logic             link_data,
    input  wire logic             link_ctrl,
    input  wire cpr_pkg::cpr_bus_req_s bus_req,
    output logic [31:0]           bus_rdata,
    output cpr_pkg::cpr_out_s     rx_out
);
    import cpr_pkg::*;

    localparam int CH_W = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;

    if (NUM_CH < 1 || NUM_CH > 16 || (int'(BASE_ADDR) + NUM_CH) > 256)
    begin : g_bad_param
        $error("cpr_rx_channel_fsm: NUM_CH or BASE_ADDR out of range");
    end

    // link pin synchronisers
    logic [2:0]  clk_sync;
    logic [2:0]  dat_sync;
    logic [2:0]  ctl_sync;

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            clk_sync <= 3'h0;
            dat_sync <= 3'h0;
            ctl_sync <= 3'h0;
        end
        else if (ce)
        begin
            clk_sync <= {clk_sync[1:0], link_clk};
            dat_sync <= {dat_sync[1:0], link_data};
            ctl_sync <= {ctl_sync[1:0], link_ctrl};
        end
    end

    // data taken from the sample just before the seen rising edge
    wire lk_edge = clk_sync[1] & ~clk_sync[2];
    wire bit_dat = dat_sync[2];
    wire bit_ctl = ctl_sync[2];

    // word deserialiser
    logic [4:0]  bit_cnt;
    logic        aligned;
    logic        word_ctl;
    logic [31:0] shreg;
    logic [31:0] word;
    logic        word_is_ctl;
    logic        word_v;
    logic        frame_err;

    wire word_done = ce && lk_edge && aligned && !bit_ctl && bit_cnt == `CPR_BIT_LAST;
    wire resync    = ce && lk_edge && aligned && bit_ctl && bit_cnt != `CPR_BIT_FIRST;

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            bit_cnt     <= `CPR_BIT_FIRST;
            aligned     <= 1'b0;
            word_ctl    <= 1'b0;
            shreg       <= 32'h0;
            word        <= 32'h0;
            word_is_ctl <= 1'b0;
            word_v      <= 1'b0;
            frame_err   <= 1'b0;
        end
        else if (ce)
        begin
            word_v    <= word_done;
            frame_err <= resync;
            if (lk_edge && bit_ctl)
            begin
                shreg    <= {shreg[30:0], bit_dat};
                bit_cnt  <= `CPR_BIT_ONE;
                word_ctl <= 1'b1;
                aligned  <= 1'b1;
            end
            else if (lk_edge && aligned)
            begin
                shreg   <= {shreg[30:0], bit_dat};
                bit_cnt <= bit_cnt + `CPR_BIT_ONE;
                if (bit_cnt == `CPR_BIT_FIRST)
                    word_ctl <= 1'b0;
            end
            if (word_done)
            begin
                word        <= {shreg[30:0], bit_dat};
                word_is_ctl <= word_ctl;
            end
        end
    end

    // control register
    logic ctrl_en;
    logic cell_mode;

    // word decode
    wire       evt       = ce && word_v && ctrl_en;
    wire       w_data    = !word_is_ctl;
    wire [3:0] w_type    = word[`CPR_TYPE_HI:`CPR_TYPE_LO];
    wire       is_adr    = word_is_ctl && w_type == `CPR_TYPE_ADR;
    wire       is_abort  = word_is_ctl && w_type == `CPR_TYPE_EXT && word[`CPR_ABORT_BIT];
    wire       w_sop     = word[`CPR_START_BIT];
    wire       w_eop     = word[`CPR_EOP_BIT];
    wire [1:0] w_nb      = word[`CPR_NBYTES_HI:`CPR_NBYTES_LO];
    wire [7:0] w_addr    = word[`CPR_ADDR_HI:`CPR_ADDR_LO];
    wire [7:0] w_off     = w_addr - BASE_ADDR;
    wire       adr_ok    = w_addr >= BASE_ADDR && w_off < 8'(NUM_CH);
    wire [2:0] eop_bytes = (w_nb == `CPR_NBYTES_FULL) ? `CPR_FULL_BYTES : {1'b0, w_nb};

    // channel owning the data words
    logic [CH_W-1:0] cur_ch;
    logic            cur_v;

    cpr_state_e        st [NUM_CH];
    logic [NUM_CH-1:0] ev_first;
    logic [NUM_CH-1:0] ev_end;
    logic [NUM_CH-1:0] ev_abort;
    logic [NUM_CH-1:0] ev_cell_end;
    logic [2*NUM_CH-1:0] st_vec;

    for (genvar gi = 0; gi < NUM_CH; gi++)
    begin : g_ch
        localparam logic [7:0] MY_ADDR = BASE_ADDR + 8'(gi);
        wire hit  = w_addr == MY_ADDR;
        wire mine = cur_v && cur_ch == CH_W'(gi);
        logic [3:0] wcnt;
        cpr_state_e next_st;

        always_comb
        begin
            next_st = st[gi];
            unique case (st[gi])
                st_idle:
                    if (evt && is_adr && hit && w_sop)
                        next_st = st_start;
                    else
                        next_st = st_idle;
                st_start:
                    if (evt && w_data && mine)
                        next_st = st_active;
                    else if (evt && is_abort && hit)
                        next_st = st_idle;
                    else if (evt && is_adr && !hit)
                        next_st = st_idle;
                    else if (evt && is_adr && w_eop && !w_sop)
                        next_st = st_idle;
                    else
                        next_st = st_start;
                st_active:
                    if (ev_cell_end[gi])
                        next_st = st_idle;
                    else if (evt && is_abort && hit)
                        next_st = st_idle;
                    else if (evt && is_adr && !hit)
                        next_st = w_eop ? st_idle : st_pause;
                    else if (evt && is_adr && hit && w_sop)
                        next_st = st_start;
                    else if (evt && is_adr && hit && w_eop)
                        next_st = st_idle;
                    else
                        next_st = st_active;
                st_pause:
                    if (evt && is_abort && hit)
                        next_st = st_idle;
                    else if (evt && is_adr && hit)
                        next_st = w_sop ? st_start : st_active;
                    else
                        next_st = st_pause;
            endcase
        end

        assign ev_first[gi]    = evt && st[gi] == st_start && w_data && mine;
        assign ev_end[gi]      = evt && st[gi] == st_active && is_adr && w_eop;
        assign ev_cell_end[gi] = evt && cell_mode && st[gi] == st_active && w_data
                                 && mine && wcnt == `CPR_CELL_LAST;
        assign ev_abort[gi]    = evt && hit && (
                                 (st[gi] == st_active && (is_abort || (is_adr && w_sop && !w_eop)))
                                 || (st[gi] == st_pause && (is_abort || (is_adr && w_sop))));
        assign st_vec[2*gi +: 2] = st[gi];

        always_ff @(posedge ref_clk or negedge reset_n)
        begin
            if (!reset_n)
            begin
                st[gi] <= st_idle;
                wcnt   <= 4'h0;
            end
            else if (ce)
            begin
                st[gi] <= next_st;
                if (ev_first[gi])
                    wcnt <= `CPR_WCNT_ONE;
                else if (evt && w_data && mine && st[gi] == st_active)
                    wcnt <= wcnt + `CPR_WCNT_ONE;
            end
        end
    end

    // abort channel encoder
    logic [CH_W-1:0] ab_idx;
    always_comb
    begin
        ab_idx = '0;
        for (int k = 0; k < NUM_CH; k++)
            if (ev_abort[k])
                ab_idx = CH_W'(k);
    end

    wire       data_ev  = evt && w_data && cur_v;
    wire       cur_act  = st[cur_ch] == st_active;
    wire [7:0] cur_addr = BASE_ADDR + 8'(cur_ch);

    // per-channel hold of the newest word
    logic [31:0]       held [NUM_CH];
    logic [NUM_CH-1:0] held_sop;
    logic [NUM_CH-1:0] held_v;
    logic [31:0]       pkt_cnt;
    logic [31:0]       abort_cnt;
    logic [31:0]       frame_cnt;

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rx_out    <= '0;
            held      <= '{default: 32'h0};
            held_sop  <= '0;
            held_v    <= '0;
            cur_ch    <= '0;
            cur_v     <= 1'b0;
            pkt_cnt   <= 32'h0;
            abort_cnt <= 32'h0;
            frame_cnt <= 32'h0;
        end
        else if (ce)
        begin
            rx_out.valid <= 1'b0;
            rx_out.start <= 1'b0;
            rx_out.abort <= 1'b0;
            if (frame_err)
                frame_cnt <= frame_cnt + `CPR_CNT_ONE;
            if (evt && is_adr)
            begin
                cur_v  <= adr_ok;
                cur_ch <= CH_W'(w_off);
            end
            if (|ev_abort)
            begin
                rx_out.abort      <= 1'b1;
                rx_out.abort_chan <= BASE_ADDR + 8'(ab_idx);
                held_v[ab_idx]    <= 1'b0;
                abort_cnt         <= abort_cnt + `CPR_CNT_ONE;
            end
            if (data_ev && ev_first[cur_ch])
            begin
                rx_out.start <= 1'b1;
                rx_out.chan  <= cur_addr;
                if (cell_mode)
                begin
                    rx_out.valid <= 1'b1;
                    rx_out.sop   <= 1'b1;
                    rx_out.eop   <= 1'b0;
                    rx_out.bytes <= `CPR_FULL_BYTES;
                    rx_out.data  <= word;
                end
                else
                begin
                    held[cur_ch]     <= word;
                    held_sop[cur_ch] <= 1'b1;
                    held_v[cur_ch]   <= 1'b1;
                end
            end
            else if (data_ev && cur_act)
            begin
                rx_out.chan <= cur_addr;
                if (cell_mode)
                begin
                    rx_out.valid <= 1'b1;
                    rx_out.sop   <= 1'b0;
                    rx_out.eop   <= ev_cell_end[cur_ch];
                    rx_out.bytes <= `CPR_FULL_BYTES;
                    rx_out.data  <= word;
                    if (ev_cell_end[cur_ch])
                        pkt_cnt <= pkt_cnt + `CPR_CNT_ONE;
                end
                else
                begin
                    rx_out.valid     <= held_v[cur_ch];
                    rx_out.sop       <= held_sop[cur_ch];
                    rx_out.eop       <= 1'b0;
                    rx_out.bytes     <= `CPR_FULL_BYTES;
                    rx_out.data      <= held[cur_ch];
                    held[cur_ch]     <= word;
                    held_sop[cur_ch] <= 1'b0;
                    held_v[cur_ch]   <= 1'b1;
                end
            end
            else if (cur_v && ev_end[cur_ch] && held_v[cur_ch])
            begin
                rx_out.valid   <= 1'b1;
                rx_out.chan    <= cur_addr;
                rx_out.sop     <= held_sop[cur_ch];
                rx_out.eop     <= 1'b1;
                rx_out.bytes   <= eop_bytes;
                rx_out.data    <= held[cur_ch];
                held_v[cur_ch] <= 1'b0;
                pkt_cnt        <= pkt_cnt + `CPR_CNT_ONE;
            end
        end
    end

    // register port
    wire [31:0] status_word = {16'h0, 8'(cur_ch), 6'h0, cur_v, aligned};
    wire [31:0] rd_mux =
        (bus_req.addr == `CPR_REG_CTRL)     ? {30'h0, cell_mode, ctrl_en} :
        (bus_req.addr == `CPR_REG_STATUS)   ? status_word :
        (bus_req.addr == `CPR_REG_CHSTATE)  ? 32'(st_vec) :
        (bus_req.addr == `CPR_REG_PKTCNT)   ? pkt_cnt :
        (bus_req.addr == `CPR_REG_ABORTCNT) ? abort_cnt :
        (bus_req.addr == `CPR_REG_FRAMEERR) ? frame_cnt : 32'h0;

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_en   <= `CPR_CTRL_EN_RST;
            cell_mode <= `CPR_CTRL_CELL_RST;
            bus_rdata <= 32'h0;
        end
        else if (ce)
        begin
            bus_rdata <= bus_req.rd ? rd_mux : 32'h0;
            if (bus_req.wr && bus_req.addr == `CPR_REG_CTRL)
            begin
                ctrl_en   <= bus_req.wdata[`CPR_CTRL_EN_BIT];
                cell_mode <= bus_req.wdata[`CPR_CTRL_CELL_BIT];
            end
        end
    end

    // checks on the word deserialiser, channel 0 and the output stream
    wire hit0 = w_addr == BASE_ADDR;

    property p_idle_hold;
        @(posedge ref_clk) disable iff (!reset_n)
        st[0] == st_idle && !(evt && is_adr && hit0 && w_sop) |=> st[0] == st_idle;
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("idle channel left idle");

    property p_idle_start;
        @(posedge ref_clk) disable iff (!reset_n)
        st[0] == st_idle && evt && is_adr && hit0 && w_sop |=> st[0] == st_start;
    endproperty
    a_idle_start: assert property (p_idle_start) else $error("start word not taken");

    property p_first_data;
        @(posedge ref_clk) disable iff (!reset_n)
        ev_first[0] |=> st[0] == st_active ##0 rx_out.start && rx_out.chan == BASE_ADDR;
    endproperty
    a_first_data: assert property (p_first_data) else $error("first data not active");

    property p_start_other;
        @(posedge ref_clk) disable iff (!reset_n)
        st[0] == st_start && evt && is_adr && !hit0 |=> st[0] == st_idle;
    endproperty
    a_start_other: assert property (p_start_other) else $error("start kept on switch");

    property p_cell_end;
        @(posedge ref_clk) disable iff (!reset_n)
        ev_cell_end[0] |=> st[0] == st_idle && rx_out.valid && rx_out.eop;
    endproperty
    a_cell_end: assert property (p_cell_end) else $error("cell not closed at 52 bytes");

    property p_resume;
        @(posedge ref_clk) disable iff (!reset_n)
        st[0] == st_pause && evt && is_adr && hit0 && !w_sop |=> st[0] == st_active;
    endproperty
    a_resume: assert property (p_resume) else $error("paused transfer not resumed");

    property p_pause_abort;
        @(posedge ref_clk) disable iff (!reset_n)
        st[0] == st_pause && evt && is_abort && hit0
        |=> st[0] == st_idle && rx_out.abort && rx_out.abort_chan == BASE_ADDR;
    endproperty
    a_pause_abort: assert property (p_pause_abort) else $error("pause abort lost");

    property p_notice;
        @(posedge ref_clk) disable iff (!reset_n)
        rx_out.start |-> $past(data_ev) && $past(st[0] != st_active || cur_ch != '0);
    endproperty
    a_notice: assert property (p_notice) else $error("start notice without data");

    property p_hold_last;
        @(posedge ref_clk) disable iff (!reset_n)
        !cell_mode && rx_out.valid && rx_out.eop |-> $past(evt && is_adr && w_eop);
    endproperty
    a_hold_last: assert property (p_hold_last) else $error("last word left early");

    property p_ext_abort;
        @(posedge ref_clk) disable iff (!reset_n)
        (st[0] == st_start || st[0] == st_active) && evt && is_abort && hit0
        |=> st[0] == st_idle;
    endproperty
    a_ext_abort: assert property (p_ext_abort) else $error("abort word ignored");

    property p_reset_idle;
        @(posedge ref_clk) disable iff (!reset_n)
        $rose(reset_n) |-> st[0] == st_idle && !rx_out.valid;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset");

    property p_word_span;
        @(posedge ref_clk) disable iff (!reset_n)
        word_v |-> aligned && $past(bit_cnt) == `CPR_BIT_LAST;
    endproperty
    a_word_span: assert property (p_word_span) else $error("word not 32 bits");

    c_packet: cover property (@(posedge ref_clk) disable iff (!reset_n)
        rx_out.valid && rx_out.eop && !cell_mode);
    c_cell:   cover property (@(posedge ref_clk) disable iff (!reset_n)
        ev_cell_end[0]);
    c_pause:  cover property (@(posedge ref_clk) disable iff (!reset_n)
        st[0] == st_pause ##1 st[0] == st_active);
    c_abort:  cover property (@(posedge ref_clk) disable iff (!reset_n)
        rx_out.abort);

endmodule
`default_nettype wire

/* shared/cpr_defines.svh */
// constants for the per-channel cell/packet receive block
`ifndef CPR_DEFINES_SVH
`define CPR_DEFINES_SVH

// serial word framing
`define CPR_WORD_W          32
`define CPR_BIT_FIRST       5'h00
`define CPR_BIT_ONE         5'h01
`define CPR_BIT_LAST        5'h1f

// control word layout
`define CPR_TYPE_HI         31
`define CPR_TYPE_LO         28
`define CPR_TYPE_ADR        4'h1
`define CPR_TYPE_FLOW       4'h2
`define CPR_TYPE_EXT        4'h3
`define CPR_TYPE_USER       4'h4
`define CPR_START_BIT       27
`define CPR_EOP_BIT         26
`define CPR_ABORT_BIT       27
`define CPR_NBYTES_HI       25
`define CPR_NBYTES_LO       24
`define CPR_ADDR_HI         7
`define CPR_ADDR_LO         0
`define CPR_NBYTES_FULL     2'h0
`define CPR_FULL_BYTES      3'h4

// cell mode: 52 bytes in 13 words
`define CPR_CELL_LAST       4'hc
`define CPR_WCNT_ONE        4'h1

// register map
`define CPR_REG_CTRL        8'h00
`define CPR_REG_STATUS      8'h04
`define CPR_REG_CHSTATE     8'h08
`define CPR_REG_PKTCNT      8'h0c
`define CPR_REG_ABORTCNT    8'h10
`define CPR_REG_FRAMEERR    8'h14
`define CPR_CTRL_EN_BIT     0
`define CPR_CTRL_CELL_BIT   1
`define CPR_CTRL_EN_RST     1'b1
`define CPR_CTRL_CELL_RST   1'b0
`define CPR_STAT_ALIGN_BIT  0
`define CPR_STAT_CURV_BIT   1
`define CPR_STAT_CUR_LO     8
`define CPR_CNT_ONE         32'h0000_0001

`endif

/* shared/cpr_pkg.sv */
// types for the per-channel cell/packet receive block
package cpr_pkg;

    typedef enum logic [1:0] {
        st_idle   = 2'b00,
        st_start  = 2'b01,
        st_active = 2'b10,
        st_pause  = 2'b11
    } cpr_state_e;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } cpr_bus_req_s;

    typedef struct packed {
        logic        valid;
        logic        start;
        logic        sop;
        logic        eop;
        logic [2:0]  bytes;
        logic [7:0]  chan;
        logic [31:0] data;
        logic        abort;
        logic [7:0]  abort_chan;
    } cpr_out_s;

endpackage

/* verif/cpr_link_partner.sv */
// serial link sender model driving words bit by bit
`timescale 1ns/1ps
`default_nettype none
module cpr_link_partner (
    output logic link_clk,
    output logic link_data,
    output logic link_ctrl
);
    initial
    begin
        link_clk  = 1'b0;
        link_data = 1'b0;
        link_ctrl = 1'b0;
    end
    // one word over 32 link clocks; link clock stands still between words
    task automatic send(input logic c, input logic [31:0] w);
        for (int i = 31; i >= 0; i--)
        begin
            link_data = w[i];
            link_ctrl = c && (i == 31);
            #32 link_clk = 1'b1;
            #32 link_clk = 1'b0;
        end
        link_data = ~w[0];
        link_ctrl = 1'b0;
    endtask
endmodule
`default_nettype wire

/* verif/tb_cpr_rx_channel_fsm.sv */
// self-checking bench for the serial cell/packet receive block
`timescale 1ns/1ps
`default_nettype none
module tb_cpr_rx_channel_fsm;
    import cpr_pkg::*;
    logic         ref_clk = 1'b0;
    logic         reset_n = 1'b0;
    logic         ce = 1'b1;
    wire          link_clk, link_data, link_ctrl;
    cpr_bus_req_s bus_req = '0;
    logic [31:0]  bus_rdata;
    cpr_out_s     rx_out;
    int           fail_count = 0;
    int           total_checks = 0;
    int           cycles = 0;
    logic [49:0]  exp_q[$];
    logic [31:0]  d[0:15];

    always #4 ref_clk = ~ref_clk;

    cpr_rx_channel_fsm u_cpr_rx_channel_fsm (.ref_clk(ref_clk), .reset_n(reset_n), .ce(ce),
        .link_clk(link_clk), .link_data(link_data), .link_ctrl(link_ctrl),
        .bus_req(bus_req), .bus_rdata(bus_rdata), .rx_out(rx_out));
    cpr_link_partner u_partner (.link_clk(link_clk), .link_data(link_data), .link_ctrl(link_ctrl));

    task automatic check(input logic [49:0] seen, input logic [49:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        if (fail_count == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic pop(input logic [49:0] seen);
        if (exp_q.size() == 0)
            check(seen, '1);
        else
            check(seen, exp_q.pop_front());
    endtask
    // downstream events compared in a fixed order: notice, word, abort
    always @(posedge ref_clk)
    begin
        #1;
        cycles++;
        if (rx_out.start === 1'b1) pop({2'h1, 40'h0, rx_out.chan});
        if (rx_out.valid === 1'b1) pop({2'h2, rx_out.sop, rx_out.eop, rx_out.bytes,
            rx_out.chan, rx_out.data, 3'h0});
        if (rx_out.abort === 1'b1) pop({2'h3, 40'h0, rx_out.abort_chan});
        if (cycles == 25000)
        begin
            fail_count++;
            end_of_test();
        end
    end

    function automatic logic [31:0] adr(input logic [3:0] f, input logic [7:0] a);
        return {4'h1, f, 16'h0, a};
    endfunction
    task automatic es(input logic [7:0] ch);
        exp_q.push_back({2'h1, 40'h0, ch});
    endtask
    task automatic ea(input logic [7:0] ch);
        exp_q.push_back({2'h3, 40'h0, ch});
    endtask
    task automatic ev(input logic [4:0] f, input logic [7:0] ch, input logic [31:0] w);
        exp_q.push_back({2'h2, f, ch, w, 3'h0});
    endtask
    task automatic cw(input logic [31:0] w);
        u_partner.send(1'b1, w);
    endtask
    task automatic dw(input logic [31:0] w);
        u_partner.send(1'b0, w);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk) bus_req <= {1'b1, 1'b0, a, v};
        @(posedge ref_clk) bus_req <= '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk) bus_req <= {1'b0, 1'b1, a, 32'h0};
        @(posedge ref_clk) bus_req <= '0;
        #1 check({18'h0, bus_rdata}, {18'h0, exp});
    endtask

    initial
    begin
        void'($urandom(32'h243c));
        for (int i = 0; i < 16; i++)
            d[i] = $urandom;
        repeat (20) @(posedge ref_clk);
        reset_n <= 1'b1;
        rd(8'h00, 32'h1);
        rd(8'h08, 32'h0);
        rd(8'h20, 32'h0);
        // link words ignored while the receiver is disabled
        wr(8'h00, 32'h0);
        rd(8'h00, 32'h0);
        cw(adr(4'h8, 8'h01));
        dw(d[15]);
        rd(8'h08, 32'h0);
        wr(8'h00, 32'h1);
        rd(8'h00, 32'h1);
        // packet on channel 0 with a user word inside
        cw(adr(4'h8, 8'h00));
        es(0); dw(d[0]);
        cw(32'h4000_0000);
        ev(5'h14, 0, d[0]); dw(d[1]);
        ev(5'h0a, 0, d[1]); cw(adr(4'h6, 8'h03));
        // pause, resume, then aborts in active and in pause
        cw(adr(4'h8, 8'h00));
        es(0); dw(d[2]);
        cw(adr(4'h0, 8'h02));
        dw(d[3]);
        cw(adr(4'h0, 8'h00));
        ev(5'h14, 0, d[2]); dw(d[4]);
        ea(0); cw(32'h3800_0000);
        cw(adr(4'h8, 8'h00));
        es(0); dw(d[5]);
        cw(adr(4'h0, 8'h03));
        cw(32'h3800_0001);
        ea(0); cw(32'h3800_0000);
        rd(8'h08, 32'h0);
        // start state exits, then restart and ends from active
        cw(adr(4'h8, 8'h00));
        cw(adr(4'h4, 8'h00));
        dw(d[6]);
        cw(adr(4'h8, 8'h00));
        cw(adr(4'h0, 8'h02));
        dw(d[7]);
        cw(adr(4'h8, 8'h00));
        cw(adr(4'h0, 8'h00));
        es(0); dw(d[8]);
        ea(0); cw(adr(4'h8, 8'h00));
        es(0); dw(d[9]);
        ev(5'h1c, 0, d[9]); cw(adr(4'hc, 8'h00));
        es(0); dw(d[10]);
        ev(5'h19, 0, d[10]); cw(adr(4'h5, 8'h00));
        // cell mode: 13 words, a 14th is dropped
        wr(8'h00, 32'h3);
        rd(8'h00, 32'h3);
        cw(adr(4'h8, 8'h00));
        for (int i = 0; i < 13; i++)
        begin
            if (i == 0)
                es(0);
            ev({i == 0, i == 12, 3'h4}, 0, d[i]);
            dw(d[i]);
        end
        dw(d[13]);
        rd(8'h08, 32'h0);
        rd(8'h0c, 32'h4);
        rd(8'h10, 32'h3);
        rd(8'h04, 32'h3);
        rd(8'h14, 32'h0);
        repeat (20) @(posedge ref_clk);
        check(50'(exp_q.size()), 50'h0);
        end_of_test();
    end
endmodule
`default_nettype wire
